// [testbench.sv]
/*
  Self-checking bench of the management block: status pins, both maps, live values, fault latch.
  Assumes the host model in its own file and the design's package compiled first.
*/
`timescale 1ns/1ns
module testbench;
  import tmm_pkg::*;
  localparam logic [4:0][15:0] GAIN = {16'h0200, 16'h0100, 16'h0100, 16'h0100, 16'h0080};
  localparam logic [4:0][15:0] OFFS = {16'h0010, 16'h0000, 16'h0000, 16'h0003, 16'h0000};
  logic         clk_sys, reset, scl_link, sda_pull, sda_w, sda_o, sda_oe, ack;
  logic         lost, fault_in, tx_off, receive_signal_lost, tx_fault, laser_enable;
  tmm_monitor_t mon;
  logic [7:0]   rq[$];
  int           fail_count = 0;
  int           comparisons = 0;

  assign sda_w = !(sda_pull || (sda_oe && !sda_o));

  tmm_top #(.CAL_GAIN(GAIN), .CAL_OFFSET(OFFS)) DUT (
    .clk_sys(clk_sys), .reset(reset), .scl_link(scl_link), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .optical_input_lost(lost), .laser_fault_detect(fault_in), .tx_off(tx_off),
    .monitor_raw(mon), .receive_signal_lost(receive_signal_lost), .tx_fault(tx_fault),
    .laser_enable(laser_enable));

  tmm_host_model host (.scl_link(scl_link), .sda_pull(sda_pull), .sda_wire(sda_w));

  // ==========================================================================
  // Compare and closing tasks
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // Bus access tasks
  task automatic addr(input logic [7:0] a, input logic exp);
    host.start();
    host.put(a, ack);
    check_bit("address ack", exp, ack);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] ptr, input logic [7:0] d[$]);
    addr(a, 1'b0);
    host.put(ptr, ack);
    check_bit("pointer ack", 1'b0, ack);
    foreach (d[i])
    begin
      host.put(d[i], ack);
      check_bit("data ack", 1'b0, ack);
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] ptr, input int n);
    logic [7:0] b;
    addr(a, 1'b0);
    host.put(ptr, ack);
    check_bit("pointer ack", 1'b0, ack);
    addr(a | 8'h01, 1'b0);
    rq.delete();
    for (int i = 0; i < n; i++)
    begin
      host.get(i == n - 1, b);
      rq.push_back(b);
    end
    host.stop();
  endtask

  // Reads the live words and the status byte in one sequential burst.
  task automatic live(input logic [7:0] status);
    logic [15:0] w;
    logic [79:0] raw;
    raw = mon;
    rd(8'hA2, 8'h60, 15);
    for (int c = 4; c >= 0; c--)
    begin
      w = 16'(((32'(raw[c*16 +: 16]) * 32'(GAIN[c])) >> 8) + 32'(OFFS[c]));
      check_byte("live msb", w[15:8], rq[2*(4-c)]);
      check_byte("live lsb", w[7:0], rq[2*(4-c)+1]);
    end
    check_byte("status byte", status, rq[14]);
  endtask

  // ==========================================================================
  // Clock, watchdog and test sequence
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (80000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end

  initial
  begin
    reset = 1'b1;
    lost = 1'b0;
    fault_in = 1'b0;
    tx_off = 1'b0;
    mon = {16'h1234, 16'h8001, 16'h00FF, 16'h7F80, 16'h0302};
    repeat (10) @(negedge clk_sys);
    reset = 1'b0;
    repeat (8) @(negedge clk_sys);
    check_bit("loss pin", 1'b0, receive_signal_lost);
    check_bit("laser enable", 1'b1, laser_enable);
    lost = 1'b1;
    repeat (5) @(negedge clk_sys);
    check_bit("loss pin", 1'b1, receive_signal_lost);
    wr(8'hA2, 8'h05, {8'h12, 8'h34});
    rd(8'hA2, 8'h05, 2);
    check_byte("diag 05", 8'h12, rq[0]);
    check_byte("diag 06", 8'h34, rq[1]);
    wr(8'hA0, 8'hFF, {8'hAB, 8'hCD});
    rd(8'hA0, 8'hFF, 2);
    check_byte("id FF", 8'hAB, rq[0]);
    check_byte("id 00", 8'hCD, rq[1]);
    rd(8'hA2, 8'h00, 1);
    check_byte("diag 00", 8'h00, rq[0]);
    addr(8'hB0, 1'b1);
    host.stop();
    addr(8'hA4, 1'b1);
    host.stop();
    live(8'h02);
    @(negedge clk_sys);
    mon = {16'h0F0F, 16'h1111, 16'hFFFF, 16'h2000, 16'hA5A5};
    live(8'h02);
    @(negedge clk_sys);
    fault_in = 1'b1;
    repeat (5) @(negedge clk_sys);
    fault_in = 1'b0;
    lost = 1'b0;
    repeat (6) @(negedge clk_sys);
    check_bit("fault latch", 1'b1, tx_fault);
    check_bit("laser enable", 1'b0, laser_enable);
    live(8'h04);
    // Only one rising edge of transmitter-off in the whole run keeps the host spacing rule.
    @(negedge clk_sys);
    tx_off = 1'b1;
    repeat (6) @(negedge clk_sys);
    check_bit("fault latch", 1'b0, tx_fault);
    check_bit("laser enable", 1'b0, laser_enable);
    live(8'h80);
    @(negedge clk_sys);
    tx_off = 1'b0;
    repeat (6) @(negedge clk_sys);
    check_bit("laser enable", 1'b1, laser_enable);
    test_done();
  end
endmodule // testbench

// [tmm_calib.sv]
/*
  Calibration of the five raw monitor readings into engineering units (gain in 8.8 fixed point,
  then offset). Assumes raw readings arrive on clk_sys from logic in the same domain.
*/
`timescale 1ns/1ns
`include "tmm_consts.svh"
module tmm_calib #(
  parameter logic [4:0][15:0] CAL_GAIN   = {5{`TMM_GAIN_UNITY}},
  parameter logic [4:0][15:0] CAL_OFFSET = {5{`TMM_OFFSET_NONE}}
)(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire tmm_pkg::tmm_monitor_t raw,
  output tmm_pkg::tmm_monitor_t      cal
);
  import tmm_pkg::*;

  function automatic logic [15:0] cal_word(input logic [15:0] r, input logic [15:0] g, input logic [15:0] o);
    logic [31:0] prod;
    prod = r * g;
    cal_word = prod[`TMM_FRAC_BITS +: 16] + o;
  endfunction

  logic [4:0][15:0] raw_a;
  logic [4:0][15:0] cal_d;
  tmm_monitor_t     cal_q;

  assign raw_a = raw;
  assign cal   = cal_q;

  // ==========================================================================
  // Calibration pipeline
  // Recomputed on every edge so the map's snapshot, taken at each start, holds the latest reading.
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      cal_d[i] = cal_word(raw_a[i], CAL_GAIN[i], CAL_OFFSET[i]);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      cal_q <= '0;
    else
      cal_q <= cal_d;
  end

  // ==========================================================================
  // Checks
  property p_cal_exact;
    @(posedge clk_sys) disable iff (reset)
      1'b1 |=> cal_q.temperature == cal_word($past(raw.temperature), CAL_GAIN[4], CAL_OFFSET[4]);
  endproperty
  a_cal_exact: assert property (p_cal_exact) else $error("temperature not calibrated");

endmodule // tmm_calib

// [tmm_consts.svh]
/*
  Constants of the transceiver management memory: two-wire device addresses, map byte positions,
  status bit positions and reset values. Assumes inclusion by bare name from the design files.
*/
`ifndef TMM_CONSTS_SVH
`define TMM_CONSTS_SVH

// ==========================================================================
// Two-wire device addresses (7-bit form of the 8-bit write addresses)
`define TMM_DEVADDR_ID       7'h50
`define TMM_DEVADDR_DIAG     7'h51
`define TMM_DEVADDR_TEST     7'h58

// ==========================================================================
// Diagnostic map layout
`define TMM_LIVE_FIRST       8'h60
`define TMM_LIVE_LAST        8'h69
`define TMM_STATUS_BYTE      8'h6E
`define TMM_STATUS_LOST_BIT  1
`define TMM_STATUS_FAULT_BIT 2
`define TMM_STATUS_TXOFF_BIT 7

// ==========================================================================
// Reset values and counts
`define TMM_MEM_RESET        8'h00
`define TMM_PTR_RESET        8'h00
`define TMM_LAST_BIT         4'h7
`define TMM_ACK_BIT          4'h8
`define TMM_ACK_RELEASE      4'h9
`define TMM_GAIN_UNITY       16'h0100
`define TMM_OFFSET_NONE      16'h0000
`define TMM_FRAC_BITS        8

`endif

// [tmm_host_model.sv]
/*
  Behavioural two-wire host for the management block: drives SCL and pulls SDA low or lets it go.
  Assumes the bench resolves the SDA wire with a pull-up and feeds that level back on sda_wire.
*/
`timescale 1ns/1ns
module tmm_host_model #(
  parameter int Q = 530
)(
  output logic      scl_link,
  output logic      sda_pull,
  input  wire logic sda_wire
);
  // ==========================================================================
  // Bus phases
  // SDA only moves a third of a bit period after SCL falls, so no edge can pass for a start or stop.
  initial
  begin
    scl_link = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic bit_cycle(input logic pull, output logic seen);
    #Q sda_pull = pull;
    #Q scl_link = 1'b1;
    #(Q/2) seen = sda_wire;
    #(Q/2) scl_link = 1'b0;
  endtask

  task automatic start();
    #Q sda_pull = 1'b0;
    #Q scl_link = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl_link = 1'b0;
  endtask

  task automatic stop();
    #Q sda_pull = 1'b1;
    #Q scl_link = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask

  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(~b[i], s);
    bit_cycle(1'b0, ack);
  endtask

  task automatic get(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(1'b0, b[i]);
    bit_cycle(~last, s);
  endtask
endmodule // tmm_host_model

// [tmm_pkg.sv]
/*
  Types of the transceiver management memory: monitor record, protocol states and byte kinds.
  Assumes nothing of its surroundings.
*/
package tmm_pkg;

  typedef struct packed {
    logic [15:0] temperature;
    logic [15:0] supply_voltage;
    logic [15:0] laser_bias;
    logic [15:0] tx_power;
    logic [15:0] rx_power;
  } tmm_monitor_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100
  } tmm_state_t;

  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_PTR  = 2'b01,
    K_DATA = 2'b10
  } tmm_kind_t;

endpackage

// [tmm_top.sv]
/*
  Management side of the optical transceiver: receive-loss and transmit-fault status pins,
  transmitter-off handling, and a two-wire target serving an identification map and a
  diagnostic map of 256 bytes each. Assumes open-drain SDA with an external pull-up, SCL
  driven only by the host, and raw monitor readings produced on clk_sys.
*/
// Functional notes
// - Loss output is low with usable optical input, high when input is unusable.
// - Loss status is readable as bit 1 of diagnostic byte 110.
// - Identification memory is read with the serial EEPROM two-wire protocol, device as target.
// - Answer at device address 0xA0 with a 256-byte identification map.
// - Address 0xB0 is reserved for internal test; the host must not rely on it.
// - Answer at device address 0xA2 with a separate 256-byte diagnostic map.
// - Diagnostic map shows continuously updated temperature, voltage, bias, transmit and receive power; here refreshed only at each start.
// - Monitored values are calibrated inside before the host reads them.
// - Transmit fault status is readable as bit 2 of diagnostic byte 110.
// - Transmitter is off while transmitter-off is high or open, on while low.
// - A laser fault latches the fault output and stops the laser until transmitter-off toggles.
`timescale 1ns/1ns
`include "tmm_consts.svh"
module tmm_top #(
  parameter logic [4:0][15:0] CAL_GAIN   = {5{`TMM_GAIN_UNITY}},
  parameter logic [4:0][15:0] CAL_OFFSET = {5{`TMM_OFFSET_NONE}}
)(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 scl_link,
  input  wire logic                 sda_i,
  output logic                      sda_o,
  output logic                      sda_oe,
  input  wire logic                 optical_input_lost,
  input  wire logic                 laser_fault_detect,
  input  wire logic                 tx_off,
  input  wire tmm_pkg::tmm_monitor_t monitor_raw,
  output logic                      receive_signal_lost,
  output logic                      tx_fault,
  output logic                      laser_enable
);
  import tmm_pkg::*;

  // ==========================================================================
  // Link domain: bits are taken on the host's own SCL rising edge.
  // The byte is read by clk_sys only after the synchronised SCL rise, so it has been stable for
  // at least two clk_sys cycles and stays stable until the next SCL rise.
  logic [7:0] link_d;
  logic [7:0] link_q;

  always_comb
  begin
    link_d = {link_q[6:0], sda_i};
  end

  always_ff @(posedge scl_link)
  begin
    link_q <= link_d;
  end

  // ==========================================================================
  // Pin synchronisers: 0 scl, 1 sda, 2 loss, 3 fault, 4 transmitter-off
  logic [4:0] pin_raw;
  logic [4:0] sync_m_d;
  logic [4:0] sync_m_q;
  logic [4:0] sync_s_q;
  logic [4:0] sync_p_q;
  logic       scl_s;
  logic       sda_s;
  logic       lost_s;
  logic       fault_s;
  logic       txoff_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_ev;
  logic       stop_ev;
  logic       txoff_edge;

  assign pin_raw    = {tx_off, laser_fault_detect, optical_input_lost, sda_i, scl_link};
  assign scl_s      = sync_s_q[0];
  assign sda_s      = sync_s_q[1];
  assign lost_s     = sync_s_q[2];
  assign fault_s    = sync_s_q[3];
  assign txoff_s    = sync_s_q[4];
  assign scl_rise   = scl_s && !sync_p_q[0];
  assign scl_fall   = !scl_s && sync_p_q[0];
  assign start_ev   = scl_s && sync_p_q[0] && sync_p_q[1] && !sda_s;
  assign stop_ev    = scl_s && sync_p_q[0] && !sync_p_q[1] && sda_s;
  assign txoff_edge = txoff_s ^ sync_p_q[4];

  always_comb
  begin
    sync_m_d = pin_raw;
  end

  // Idle levels at reset match a quiet bus and a disabled transmitter.
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sync_m_q <= 5'h13;
      sync_s_q <= 5'h13;
      sync_p_q <= 5'h13;
    end
    else
    begin
      sync_m_q <= sync_m_d;
      sync_s_q <= sync_m_q;
      sync_p_q <= sync_s_q;
    end
  end

  // ==========================================================================
  // Status pins and transmitter control
  logic lost_d;
  logic lost_q;
  logic fault_d;
  logic fault_q;
  logic laser_d;
  logic laser_q;

  always_comb
  begin
    lost_d  = lost_s;
    fault_d = fault_q;
    if (txoff_edge)
      fault_d = 1'b0;
    if (fault_s)
      fault_d = 1'b1;
    laser_d = !txoff_s && !fault_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lost_q  <= 1'b1;
      fault_q <= 1'b0;
      laser_q <= 1'b0;
    end
    else
    begin
      lost_q  <= lost_d;
      fault_q <= fault_d;
      laser_q <= laser_d;
    end
  end

  assign receive_signal_lost = lost_q;
  assign tx_fault            = fault_q;
  assign laser_enable        = laser_q;

  // ==========================================================================
  // Calibrated monitors
  tmm_monitor_t     mon_cal;
  tmm_monitor_t     snap_d;
  tmm_monitor_t     snap_q;
  logic [4:0][15:0] snap_arr;

  tmm_calib #(
    .CAL_GAIN   (CAL_GAIN),
    .CAL_OFFSET (CAL_OFFSET)
  ) u_calib (
    .clk_sys (clk_sys),
    .reset   (reset),
    .raw     (monitor_raw),
    .cal     (mon_cal)
  );

  assign snap_arr = snap_q;

  // ==========================================================================
  // Two-wire target
  tmm_state_t      st_d;
  tmm_state_t      st_q;
  tmm_kind_t       kind_d;
  tmm_kind_t       kind_q;
  logic [3:0]      cnt_d;
  logic [3:0]      cnt_q;
  logic            map_d;
  logic            map_q;
  logic            rw_d;
  logic            rw_q;
  logic            ack_d;
  logic            ack_q;
  logic            mack_d;
  logic            mack_q;
  logic [7:0]      tx_d;
  logic [7:0]      tx_q;
  logic            oe_d;
  logic            oe_q;
  logic [1:0][7:0] ptr_d;
  logic [1:0][7:0] ptr_q;
  logic [7:0]      mem_d [512];
  logic [7:0]      mem_q [512];

  // Live words are frozen at each start so a two-byte reading cannot tear between its halves.
  function automatic logic [7:0] rd_byte(input logic diag, input logic [7:0] idx);
    logic [7:0]  off;
    logic [15:0] word;
    off     = idx - `TMM_LIVE_FIRST;
    word    = (off[3:1] <= 3'h4) ? snap_arr[3'(3'h4 - off[3:1])] : 16'h0000;
    rd_byte = mem_q[{diag, idx}];
    if (diag && idx >= `TMM_LIVE_FIRST && idx <= `TMM_LIVE_LAST)
      rd_byte = off[0] ? word[7:0] : word[15:8];
    else if (diag && idx == `TMM_STATUS_BYTE)
    begin
      rd_byte                        = 8'h00;
      rd_byte[`TMM_STATUS_LOST_BIT]  = lost_q;
      rd_byte[`TMM_STATUS_FAULT_BIT] = fault_q;
      rd_byte[`TMM_STATUS_TXOFF_BIT] = txoff_s;
    end
  endfunction

  always_comb
  begin
    st_d   = st_q;
    kind_d = kind_q;
    cnt_d  = cnt_q;
    map_d  = map_q;
    rw_d   = rw_q;
    ack_d  = ack_q;
    mack_d = mack_q;
    tx_d   = tx_q;
    oe_d   = oe_q;
    ptr_d  = ptr_q;
    mem_d  = mem_q;
    snap_d = snap_q;
    if (stop_ev)
    begin
      st_d = ST_IDLE;
      oe_d = 1'b0;
    end
    else if (start_ev)
    begin
      st_d   = ST_RX;
      kind_d = K_ADDR;
      cnt_d  = 4'h0;
      oe_d   = 1'b0;
      snap_d = mon_cal;
    end
    else
    begin
      case (st_q)
        ST_RX:
          if (scl_rise)
          begin
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `TMM_LAST_BIT)
            begin
              st_d  = ST_RX_ACK;
              ack_d = 1'b1;
              case (kind_q)
                K_ADDR:
                begin
                  // The reserved test address and all others go unanswered.
                  ack_d = (link_q[7:1] == `TMM_DEVADDR_ID) || (link_q[7:1] == `TMM_DEVADDR_DIAG);
                  map_d = (link_q[7:1] == `TMM_DEVADDR_DIAG);
                  rw_d  = link_q[0];
                end
                K_PTR:
                  ptr_d[map_q] = link_q;
                default:
                begin
                  mem_d[{map_q, ptr_q[map_q]}] = link_q;
                  ptr_d[map_q] = ptr_q[map_q] + 8'h01;
                end
              endcase
            end
          end
        ST_RX_ACK:
          if (scl_fall)
          begin
            if (cnt_q == `TMM_ACK_BIT)
            begin
              oe_d  = ack_q;
              cnt_d = `TMM_ACK_RELEASE;
            end
            else
            begin
              oe_d  = 1'b0;
              cnt_d = 4'h0;
              if (!ack_q)
                st_d = ST_IDLE;
              else if (kind_q == K_ADDR && rw_q)
              begin
                st_d         = ST_TX;
                tx_d         = rd_byte(map_q, ptr_q[map_q]);
                ptr_d[map_q] = ptr_q[map_q] + 8'h01;
                oe_d         = !tx_d[7];
              end
              else
              begin
                st_d   = ST_RX;
                kind_d = (kind_q == K_ADDR) ? K_PTR : K_DATA;
              end
            end
          end
        ST_TX:
          if (scl_rise)
            cnt_d = cnt_q + 4'h1;
          else if (scl_fall)
          begin
            if (cnt_q == `TMM_ACK_BIT)
            begin
              st_d = ST_TX_ACK;
              oe_d = 1'b0;
            end
            else
            begin
              tx_d = {tx_q[6:0], 1'b0};
              oe_d = !tx_q[6];
            end
          end
        ST_TX_ACK:
          if (scl_rise)
            mack_d = !sda_s;
          else if (scl_fall)
          begin
            if (mack_q)
            begin
              st_d         = ST_TX;
              cnt_d        = 4'h0;
              tx_d         = rd_byte(map_q, ptr_q[map_q]);
              ptr_d[map_q] = ptr_q[map_q] + 8'h01;
              oe_d         = !tx_d[7];
            end
            else
              st_d = ST_IDLE;
          end
        default:
          st_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      st_q   <= ST_IDLE;
      kind_q <= K_ADDR;
      cnt_q  <= 4'h0;
      map_q  <= 1'b0;
      rw_q   <= 1'b0;
      ack_q  <= 1'b0;
      mack_q <= 1'b0;
      tx_q   <= 8'h00;
      oe_q   <= 1'b0;
      ptr_q  <= {2{`TMM_PTR_RESET}};
      snap_q <= '0;
      sda_o  <= 1'b0;
      for (int i = 0; i < 512; i++)
        mem_q[i] <= `TMM_MEM_RESET;
    end
    else
    begin
      st_q   <= st_d;
      kind_q <= kind_d;
      cnt_q  <= cnt_d;
      map_q  <= map_d;
      rw_q   <= rw_d;
      ack_q  <= ack_d;
      mack_q <= mack_d;
      tx_q   <= tx_d;
      oe_q   <= oe_d;
      ptr_q  <= ptr_d;
      snap_q <= snap_d;
      sda_o  <= 1'b0;
      mem_q  <= mem_d;
    end
  end

  assign sda_oe = oe_q;

  // ==========================================================================
  // Checks
  logic       byte_done;
  logic [7:0] status_now;

  assign byte_done = (st_q == ST_RX) && scl_rise && (cnt_q == `TMM_LAST_BIT) && !start_ev && !stop_ev;

  // A continuous assignment with constant arguments would never see the flops that the function reads.
  always_comb
  begin
    status_now = rd_byte(1'b1, `TMM_STATUS_BYTE);
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  property p_lost_pin;
    1'b1 |=> receive_signal_lost == $past(lost_s);
  endproperty
  a_lost_pin: assert property (p_lost_pin) else $error("loss output does not follow input");

  property p_lost_mirror;
    status_now[`TMM_STATUS_LOST_BIT] == receive_signal_lost;
  endproperty
  a_lost_mirror: assert property (p_lost_mirror) else $error("loss bit not mirrored");

  property p_fault_mirror;
    status_now[`TMM_STATUS_FAULT_BIT] == tx_fault;
  endproperty
  a_fault_mirror: assert property (p_fault_mirror) else $error("fault bit not mirrored");

  property p_ack_drive;
    (st_q == ST_RX_ACK) && scl_fall && (cnt_q == `TMM_ACK_BIT) && ack_q && !start_ev && !stop_ev |=> sda_oe;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");

  property p_id_ack;
    byte_done && (kind_q == K_ADDR) && (link_q[7:1] == `TMM_DEVADDR_ID) |=> ack_q && !map_q;
  endproperty
  a_id_ack: assert property (p_id_ack) else $error("identification address not taken");

  property p_diag_ack;
    byte_done && (kind_q == K_ADDR) && (link_q[7:1] == `TMM_DEVADDR_DIAG) |=> ack_q && map_q;
  endproperty
  a_diag_ack: assert property (p_diag_ack) else $error("diagnostic address not taken");

  property p_test_nack;
    byte_done && (kind_q == K_ADDR) && (link_q[7:1] == `TMM_DEVADDR_TEST) |=> !ack_q ##1 !sda_oe;
  endproperty
  a_test_nack: assert property (p_test_nack) else $error("reserved address answered");

  property p_txoff;
    txoff_s |=> !laser_enable;
  endproperty
  a_txoff: assert property (p_txoff) else $error("laser on while transmitter-off high");

  property p_fault_hold;
    tx_fault && !txoff_edge |=> tx_fault && !laser_enable;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault latch dropped");

  property p_wrap;
    byte_done && (kind_q == K_DATA) && (ptr_q[map_q] == 8'hFF) |=> ptr_q[map_q] == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");

  c_read: cover property ((st_q == ST_TX_ACK) && scl_fall && mack_q);
  c_write: cover property (byte_done && (kind_q == K_DATA));
  c_fault: cover property ($rose(tx_fault));

endmodule // tmm_top
